// ---- inc/dbe_if.sv ----
`timescale 1ns/1ps

// ************************************************************
// Link between the core end and the system debug end
// ************************************************************
interface dbe_if;
    logic extInstrBreakReq;
    logic extDataWatchReq;
    logic extDebugRequest;
    logic debugStateAck;
    logic jtagTck;
    logic jtagTms;
    logic jtagTdi;
    logic jtagTdo;

    modport core (input extInstrBreakReq, input extDataWatchReq,
        input extDebugRequest, output debugStateAck, input jtagTck,
        input jtagTms, input jtagTdi, output jtagTdo);
    modport sys (output extInstrBreakReq, output extDataWatchReq,
        output extDebugRequest, input debugStateAck, output jtagTck,
        output jtagTms, output jtagTdi, input jtagTdo);
endinterface : dbe_if

// ---- inc/dbe_pkg.sv ----
package dbe_pkg;

    // ************************************************************
    // Widths and instruction register codes
    // ************************************************************
    localparam int INSTR_W = 32;
    localparam int IR_W = 4;
    localparam logic [3:0] IR_INSERT = 4'hC;
    localparam logic [3:0] IR_RESTART = 4'h4;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_RESET = IR_BYPASS;
    localparam logic [31:0] SCAN_RESET = 32'h0000_0000;

    // ************************************************************
    // Serial port controller states, standard numbering
    // ************************************************************
    typedef enum logic [3:0] {
        TAP_RESET = 4'hF, TAP_IDLE = 4'hC, TAP_SEL_DR = 4'h7,
        TAP_CAP_DR = 4'h6, TAP_SHIFT_DR = 4'h2, TAP_EXIT1_DR = 4'h1,
        TAP_PAUSE_DR = 4'h3, TAP_EXIT2_DR = 4'h0, TAP_UPD_DR = 4'h5,
        TAP_SEL_IR = 4'h4, TAP_CAP_IR = 4'hE, TAP_SHIFT_IR = 4'hA,
        TAP_EXIT1_IR = 4'h9, TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h8,
        TAP_UPD_IR = 4'hD
    } dbe_tap_t;

    // ************************************************************
    // Debug entry modes, Gray coded along run -> entry -> halted
    // ************************************************************
    typedef enum logic [2:0] {
        DBE_RUN = 3'b000, DBE_ENTRY = 3'b001, DBE_HALTED = 3'b011,
        DBE_WATCH_WAIT = 3'b100, DBE_REQ_WAIT = 3'b110
    } dbe_mode_t;

endpackage : dbe_pkg

// ---- rtl/dbe_core_end.sv ----
`timescale 1ns/1ps

module dbe_core_end
(
    input wire logic clk,
    input wire logic rst_b,
    dbe_if.core link,
    input wire logic fetchStrobe,
    input wire logic [dbe_pkg::INSTR_W-1:0] fetchInstr,
    input wire logic fetchAbort,
    input wire logic intBreak,
    input wire logic dataAccess,
    input wire logic intWatch,
    input wire logic pipeAdvance,
    input wire logic memBusy,
    input wire logic memWriteIn,
    input wire logic irqIn,
    input wire logic abortIn,
    output logic [dbe_pkg::INSTR_W-1:0] execInstr,
    output logic execCommit,
    output logic memWriteOut,
    output logic issueStall,
    output logic instrIntCycle,
    output logic dataIntCycle,
    output logic irqAccept,
    output logic abortAccept,
    output logic insertValid,
    output logic [dbe_pkg::INSTR_W-1:0] insertInstr,
    output logic debugState
);
    import dbe_pkg::*;

    // ************************************************************
    // Pipeline capture
    // ************************************************************
    logic [INSTR_W-1:0] decInstr_reg;
    logic decValid_reg;
    logic decFresh_reg;
    logic decAbort_reg;
    logic decBrk_reg;
    logic [INSTR_W-1:0] execInstr_reg;
    logic execValid_reg;
    logic execBrk_reg;
    logic execCommit_reg;
    logic memWrite_reg;
    dbe_mode_t mode_reg, mode_next;
    logic watchPend_reg;
    logic reqMeta_reg, reqSync_reg;
    logic ack_reg;
    logic instrInt_reg, dataInt_reg, irqAcc_reg, abortAcc_reg;
    logic stall_reg;

    // Breakpoint sources merged before control sees them
    wire brkIn = link.extInstrBreakReq | intBreak;
    wire running = (mode_reg == DBE_RUN);
    wire halted = (mode_reg == DBE_HALTED);
    wire watchIn = dataAccess & (link.extDataWatchReq | intWatch);
    wire execHit = execValid_reg & execBrk_reg;
    wire doAdvance = pipeAdvance & running;
    wire execDone = execValid_reg & pipeAdvance;

    // Fetch latch at the cycle edge closing the second phase; the
    // breakpoint is sampled one edge later, giving comparators a phase
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            decInstr_reg <= 32'h0000_0000;
            decValid_reg <= 1'b0;
            decFresh_reg <= 1'b0;
            decAbort_reg <= 1'b0;
            decBrk_reg <= 1'b0;
        end
        else if (fetchStrobe && running)
        begin
            decInstr_reg <= fetchInstr;
            decValid_reg <= 1'b1;
            decFresh_reg <= 1'b1;
            decAbort_reg <= fetchAbort;
            decBrk_reg <= 1'b0;
        end
        else
        begin
            decFresh_reg <= 1'b0;
            if (doAdvance)
                decValid_reg <= 1'b0;
            // Prefetch abort wins: a bad fetch cannot be trusted
            if (decFresh_reg)
                decBrk_reg <= brkIn & ~decAbort_reg;
        end
    end

    // Execute stage; breakpointed instruction enters but never commits
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            execInstr_reg <= 32'h0000_0000;
            execValid_reg <= 1'b0;
            execBrk_reg <= 1'b0;
            execCommit_reg <= 1'b0;
        end
        else if (doAdvance)
        begin
            execInstr_reg <= decInstr_reg;
            execValid_reg <= decValid_reg;
            execBrk_reg <= decBrk_reg;
            execCommit_reg <= decValid_reg & ~decBrk_reg;
        end
        else
        begin
            execCommit_reg <= 1'b0;
            if (pipeAdvance || !running)
                execValid_reg <= 1'b0;
        end
    end

    // Older writes drain regardless of entry, so memory stays coherent
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            memWrite_reg <= 1'b0;
        else
            memWrite_reg <= memWriteIn;
    end

    // ************************************************************
    // Entry sequencing
    // ************************************************************

    // Request is retimed twice; the first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            reqMeta_reg <= 1'b0;
            reqSync_reg <= 1'b0;
        end
        else
        begin
            reqMeta_reg <= link.extDebugRequest;
            reqSync_reg <= reqMeta_reg;
        end
    end

    // Watch hit is sticky until entry; hits outside run mode are dropped
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            watchPend_reg <= 1'b0;
        else if (watchIn && running)
            watchPend_reg <= 1'b1;
        else if (mode_reg == DBE_ENTRY)
            watchPend_reg <= 1'b0;
    end

    wire restartGo;

    // Breakpoint first, then watchpoint, then request
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            DBE_RUN:
                if (execHit)
                    mode_next = DBE_ENTRY;
                else if (watchPend_reg || watchIn)
                    mode_next = DBE_WATCH_WAIT;
                else if (reqSync_reg)
                    mode_next = DBE_REQ_WAIT;
            DBE_WATCH_WAIT:
                // Imprecise: the following instruction finishes first
                if (execDone || !execValid_reg)
                    mode_next = DBE_ENTRY;
            DBE_REQ_WAIT:
                if (!execValid_reg && !memBusy)
                    mode_next = DBE_ENTRY;
            DBE_ENTRY:
                mode_next = DBE_HALTED;
            DBE_HALTED:
                if (restartGo)
                    mode_next = DBE_RUN;
            default:
                mode_next = DBE_RUN;
        endcase
    end

    // Status outputs change on the same edge as the mode, from flops
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mode_reg <= DBE_RUN;
            ack_reg <= 1'b0;
            instrInt_reg <= 1'b0;
            dataInt_reg <= 1'b0;
            irqAcc_reg <= 1'b0;
            abortAcc_reg <= 1'b0;
            stall_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            ack_reg <= (mode_next == DBE_HALTED);
            instrInt_reg <= (mode_next == DBE_HALTED);
            dataInt_reg <= (mode_next == DBE_HALTED);
            // Halted core must not be steered by the running system
            irqAcc_reg <= irqIn & (mode_next == DBE_RUN);
            abortAcc_reg <= abortIn & (mode_next != DBE_HALTED);
            stall_reg <= (mode_next != DBE_RUN);
        end
    end

    // ************************************************************
    // Serial port
    // ************************************************************
    dbe_tap_t tap_reg, tap_next;
    logic tckPrev_reg;
    logic [IR_W-1:0] irShift_reg, ir_reg;
    logic [INSTR_W-1:0] drShift_reg;
    logic insValid_reg;
    logic [INSTR_W-1:0] insInstr_reg;
    logic tdo_reg;

    wire tckRise = link.jtagTck & ~tckPrev_reg;
    wire tms = link.jtagTms;

    // Standard controller transitions
    always_comb
    begin
        case (tap_reg)
            TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    end

    // The code register loads as update-IR is left; look through to the
    // new code, or a restart scanned in only takes effect one scan later
    wire [IR_W-1:0] irNow = (tap_reg == TAP_UPD_IR) ? irShift_reg : ir_reg;

    // Restart is taken on entry to idle with the restart code loaded
    assign restartGo = tckRise & (irNow == IR_RESTART) &
        (tap_next == TAP_IDLE) & (tap_reg != TAP_IDLE);
    wire insertGo = tckRise & (tap_reg == TAP_UPD_DR) &
        (ir_reg == IR_INSERT) & halted;

    // Controller, shifters and insertion, stepped on test clock rises
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tckPrev_reg <= 1'b0;
            tap_reg <= TAP_RESET;
            irShift_reg <= IR_RESET;
            ir_reg <= IR_RESET;
            drShift_reg <= SCAN_RESET;
            insValid_reg <= 1'b0;
            insInstr_reg <= SCAN_RESET;
            tdo_reg <= 1'b0;
        end
        else
        begin
            tckPrev_reg <= link.jtagTck;
            insValid_reg <= insertGo;
            if (insertGo)
                insInstr_reg <= drShift_reg;
            if (tckRise)
            begin
                tap_reg <= tap_next;
                case (tap_reg)
                    TAP_RESET: ir_reg <= IR_RESET;
                    TAP_CAP_IR: irShift_reg <= IR_RESET;
                    TAP_SHIFT_IR:
                    begin
                        tdo_reg <= irShift_reg[0];
                        irShift_reg <= {link.jtagTdi, irShift_reg[IR_W-1:1]};
                    end
                    TAP_UPD_IR: ir_reg <= irShift_reg;
                    TAP_SHIFT_DR:
                    begin
                        tdo_reg <= drShift_reg[0];
                        drShift_reg <= {link.jtagTdi,
                            drShift_reg[INSTR_W-1:1]};
                    end
                    default: tdo_reg <= tdo_reg;
                endcase
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign link.debugStateAck = ack_reg;
    assign link.jtagTdo = tdo_reg;
    assign execInstr = execInstr_reg;
    assign execCommit = execCommit_reg;
    assign memWriteOut = memWrite_reg;
    assign issueStall = stall_reg;
    assign instrIntCycle = instrInt_reg;
    assign dataIntCycle = dataInt_reg;
    assign irqAccept = irqAcc_reg;
    assign abortAccept = abortAcc_reg;
    assign insertValid = insValid_reg;
    assign insertInstr = insInstr_reg;
    assign debugState = ack_reg;

endmodule : dbe_core_end

// ---- rtl/dbe_sys_end.sv ----
`timescale 1ns/1ps

// ************************************************************
// System side: comparator hit flops, request logic and serial driver
// ************************************************************
module dbe_sys_end
(
    input wire logic clk,
    input wire logic rst_b,
    dbe_if.sys link,
    input wire logic usrInstrBreak,
    input wire logic usrDataWatch,
    input wire logic usrDebugReq,
    input wire logic hostTck,
    input wire logic hostTms,
    input wire logic hostTdi,
    output logic hostTdo,
    output logic debugSeen
);
    import dbe_pkg::*;

    logic brk_reg, watch_reg, req_reg;
    logic tck_reg, tms_reg, tdi_reg, tdo_reg, seen_reg;

    // All requests leave from flops so the core samples clean levels;
    // the core merges its internal comparator onto the one breakpoint line
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            brk_reg <= 1'b0;
            watch_reg <= 1'b0;
            req_reg <= 1'b0;
            tck_reg <= 1'b0;
            tms_reg <= 1'b1;
            tdi_reg <= 1'b0;
            tdo_reg <= 1'b0;
            seen_reg <= 1'b0;
        end
        else
        begin
            brk_reg <= usrInstrBreak;
            watch_reg <= usrDataWatch;
            req_reg <= usrDebugReq;
            tck_reg <= hostTck;
            tms_reg <= hostTms;
            tdi_reg <= hostTdi;
            tdo_reg <= link.jtagTdo;
            seen_reg <= link.debugStateAck;
        end
    end

    assign link.extInstrBreakReq = brk_reg;
    assign link.extDataWatchReq = watch_reg;
    assign link.extDebugRequest = req_reg;
    assign link.jtagTck = tck_reg;
    assign link.jtagTms = tms_reg;
    assign link.jtagTdi = tdi_reg;
    assign hostTdo = tdo_reg;
    assign debugSeen = seen_reg;

endmodule : dbe_sys_end

// ---- tb/dbe_sva.sv ----
`timescale 1ns/1ps

// ********************
// Link checker
// ********************
module dbe_sva
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic extInstrBreakReq,
    input wire logic extDataWatchReq,
    input wire logic extDebugRequest,
    input wire logic debugStateAck,
    input wire logic jtagTck,
    input wire logic jtagTms,
    input wire logic jtagTdi,
    input wire logic jtagTdo
);
    logic [3:0] tckAge_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Cycles since the serial clock rose; saturates so idle spans stay large
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            tckAge_reg <= 4'hF;
        else if ($rose(jtagTck))
            tckAge_reg <= 4'h0;
        else if (tckAge_reg != 4'hF)
            tckAge_reg <= tckAge_reg + 4'h1;
    end

    AST_ACK_RESET:
        assert property ($rose(rst_b) |-> !debugStateAck)
        else $error("ack high at reset release");
    AST_LINK_RESET:
        assert property ($rose(rst_b) |-> jtagTms && !jtagTck && !jtagTdo)
        else $error("serial lines wrong at reset release");
    AST_TDO_ON_TCK:
        assert property ($changed(jtagTdo) |-> tckAge_reg < 4'h4)
        else $error("serial out moved without a serial clock rise");
    AST_ACK_STAYS:
        assert property (debugStateAck && tckAge_reg > 4'h8 |=> debugStateAck)
        else $error("ack dropped with the serial port quiet");
    AST_ACK_DROP:
        assert property ($fell(debugStateAck) |-> tckAge_reg < 4'h8)
        else $error("ack fell long after any serial clock");
    AST_BREAK_LAT:
        assert property ($rose(extInstrBreakReq) && !debugStateAck
            |=> !debugStateAck [*2])
        else $error("breakpoint halted too early");
    AST_WATCH_LAT:
        assert property ($rose(extDataWatchReq) && !debugStateAck
            |=> !debugStateAck)
        else $error("watchpoint halted too early");
    AST_REQ_LAT:
        assert property ($rose(extDebugRequest) && !debugStateAck
            |=> !debugStateAck [*2])
        else $error("request halted before retiming");
endmodule : dbe_sva

// ---- tb/dbe_tb_top.sv ----
`timescale 1ns/1ps

// ********************
// Both ends joined
// ********************
module dbe_tb_top;
    import dbe_pkg::*;

    logic clk = 1'b0, rst_b = 1'b0;
    logic fetchStrobe = 1'b0, fetchAbort = 1'b0, intBreak = 1'b0;
    logic dataAccess = 1'b0, intWatch = 1'b0, pipeAdvance = 1'b0;
    logic memBusy = 1'b0, memWriteIn = 1'b0, irqIn = 1'b0, abortIn = 1'b0;
    logic usrInstrBreak = 1'b0, usrDataWatch = 1'b0, usrDebugReq = 1'b0;
    logic hostTck = 1'b0, hostTms = 1'b1, hostTdi = 1'b0;
    logic [31:0] fetchInstr = 32'h0, execInstr, insertInstr;
    logic execCommit, memWriteOut, issueStall, instrIntCycle, dataIntCycle;
    logic irqAccept, abortAccept, insertValid, debugState, debugSeen, hostTdo;
    logic [31:0] insWord = 32'h0;
    int insCnt = 0, failures = 0, compares = 0;

    dbe_if lnk ();
    dbe_core_end u_dbe_core_end (.clk, .rst_b, .link(lnk), .fetchStrobe,
        .fetchInstr, .fetchAbort, .intBreak, .dataAccess, .intWatch,
        .pipeAdvance, .memBusy, .memWriteIn, .irqIn, .abortIn, .execInstr,
        .execCommit, .memWriteOut, .issueStall, .instrIntCycle,
        .dataIntCycle, .irqAccept, .abortAccept, .insertValid,
        .insertInstr, .debugState);
    dbe_sys_end u_dbe_sys_end (.clk, .rst_b, .link(lnk), .usrInstrBreak,
        .usrDataWatch, .usrDebugReq, .hostTck, .hostTms, .hostTdi,
        .hostTdo, .debugSeen);
    dbe_sva u_dbe_sva (.clk, .rst_b,
        .extInstrBreakReq(lnk.extInstrBreakReq),
        .extDataWatchReq(lnk.extDataWatchReq),
        .extDebugRequest(lnk.extDebugRequest),
        .debugStateAck(lnk.debugStateAck), .jtagTck(lnk.jtagTck),
        .jtagTms(lnk.jtagTms), .jtagTdi(lnk.jtagTdi),
        .jtagTdo(lnk.jtagTdo));

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    // Catch one-cycle insert pulses that fall between serial steps
    always @(posedge clk)
        if (insertValid === 1'b1)
        begin
            insCnt++;
            insWord = insertInstr;
        end

    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // One serial period; slow enough for the end's edge detector
    task automatic jclk(input logic tms, tdi);
        @(posedge clk);
        hostTck <= 1'b0;
        hostTms <= tms;
        hostTdi <= tdi;
        repeat (4) @(posedge clk);
        hostTck <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : jclk

    // Idle to idle through a full instruction or data scan, LSB first
    task automatic scan(input logic isIr, input logic [31:0] v, input int n);
        jclk(1'b1, 1'b0);
        if (isIr)
            jclk(1'b1, 1'b0);
        jclk(1'b0, 1'b0);
        jclk(1'b0, 1'b0);
        for (int i = 0; i < n; i++)
            jclk(i == n - 1, v[i]);
        jclk(1'b1, 1'b0);
        jclk(1'b0, 1'b0);
        repeat (8) @(posedge clk);
    endtask : scan

    task automatic wait_ack(input logic lvl, output int n);
        n = 0;
        while (lnk.debugStateAck !== lvl && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_ack

    task automatic chk_halt(input logic h);
        check("ack", lnk.debugStateAck, h);
        check("state", debugState, h);
        check("stall", issueStall, h);
        check("icycle", instrIntCycle, h);
        check("dcycle", dataIntCycle, h);
        @(posedge clk);
        #1;
        check("seen", debugSeen, h);
    endtask : chk_halt

    task automatic irq_probe(input logic expIrq, expAbt);
        @(posedge clk);
        irqIn <= 1'b1;
        abortIn <= 1'b1;
        @(posedge clk);
        irqIn <= 1'b0;
        abortIn <= 1'b0;
        #1;
        check("irq", irqAccept, expIrq);
        check("abort", abortAccept, expAbt);
    endtask : irq_probe

    task automatic restart;
        int n;
        scan(1'b1, 32'(IR_RESTART), IR_W);
        wait_ack(1'b0, n);
        chk_halt(1'b0);
    endtask : restart

    // Fetch, breakpoint due one edge after the latch, then advance
    task automatic issue(input logic [31:0] w, input logic ext, intl);
        @(posedge clk);
        fetchStrobe <= 1'b1;
        fetchInstr <= w;
        usrInstrBreak <= ext;
        @(posedge clk);
        fetchStrobe <= 1'b0;
        intBreak <= intl;
        memWriteIn <= 1'b1;
        @(posedge clk);
        usrInstrBreak <= 1'b0;
        intBreak <= 1'b0;
        pipeAdvance <= 1'b1;
        @(posedge clk);
        pipeAdvance <= 1'b0;
        memWriteIn <= 1'b0;
        #1;
        check("exec", execInstr, w);
        check("write", memWriteOut, 1'b1);
    endtask : issue

    // Breakpoint one edge late, or in time on an aborted fetch: no hit
    task automatic miss(input logic abt);
        @(posedge clk);
        fetchStrobe <= 1'b1;
        fetchAbort <= abt;
        @(posedge clk);
        fetchStrobe <= 1'b0;
        fetchAbort <= 1'b0;
        intBreak <= abt;
        @(posedge clk);
        intBreak <= 1'b1;
        pipeAdvance <= 1'b1;
        @(posedge clk);
        intBreak <= 1'b0;
        pipeAdvance <= 1'b0;
        #1;
        check("late commit", execCommit, 1'b1);
    endtask : miss

    task automatic t_refuse;
        miss(1'b0);
        miss(1'b1);
        jclk(1'b0, 1'b0);
        scan(1'b1, 32'(IR_INSERT), IR_W);
        check("tdo", hostTdo, IR_RESET[IR_W-1]);
        scan(1'b0, 32'hFFFF_0000, INSTR_W);
        check("tdo", hostTdo, SCAN_RESET[INSTR_W-1]);
        check("inserts", insCnt, 0);
        check("ack", lnk.debugStateAck, 1'b0);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_break(input logic ext);
        int n;
        irq_probe(1'b1, 1'b1);
        issue(32'h1234_5678, 1'b0, 1'b0);
        check("commit", execCommit, 1'b1);
        issue(32'hCAFE_0001, ext, !ext);
        check("commit", execCommit, 1'b0);
        wait_ack(1'b1, n);
        check("latency", n, 2);
        chk_halt(1'b1);
        irq_probe(1'b0, 1'b0);
        scan(1'b1, 32'(IR_INSERT), IR_W);
        scan(1'b0, 32'hA5C3_0F96, INSTR_W);
        check("inserts", insCnt, 1);
        check("word", insWord, 32'hA5C3_0F96);
        // Last bit out is the top bit of the word scanned in before
        check("tdo", hostTdo, 1'b1);
        insCnt = 0;
        restart();
        $display("test break %0d done", ext);
    endtask : t_break

    task automatic t_watch;
        int n;
        @(posedge clk);
        usrDataWatch <= 1'b1;
        @(posedge clk);
        dataAccess <= 1'b1;
        @(posedge clk);
        dataAccess <= 1'b0;
        usrDataWatch <= 1'b0;
        pipeAdvance <= 1'b1;
        @(posedge clk);
        pipeAdvance <= 1'b0;
        wait_ack(1'b1, n);
        chk_halt(1'b1);
        restart();
        $display("test watch done");
    endtask : t_watch

    // A request must wait while the memory stages are still busy
    task automatic t_req;
        int n;
        @(posedge clk);
        memBusy <= 1'b1;
        usrDebugReq <= 1'b1;
        repeat (12) @(posedge clk);
        memBusy <= 1'b0;
        pipeAdvance <= 1'b1;
        #1;
        check("busy", lnk.debugStateAck, 1'b0);
        @(posedge clk);
        pipeAdvance <= 1'b0;
        wait_ack(1'b1, n);
        check("req", n < 8, 1'b1);
        @(posedge clk);
        usrDebugReq <= 1'b0;
        #1;
        chk_halt(1'b1);
        restart();
        $display("test request done");
    endtask : t_req

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_refuse();
        t_break(1'b1);
        t_break(1'b0);
        t_watch();
        t_req();
        conclude();
    end

    // Run needs about 2000 clocks; ten times that means a hang
    initial
    begin
        #(25 * 20000);
        failures++;
        conclude();
    end
endmodule : dbe_tb_top
